// ---- src/pump_fault_pkg.sv ----
// Purpose: Shared constants and types for the pump fault supervisor
// Assumes: 100 MHz core clock, temperatures in whole degrees Celsius
// Notes: Long delays are shortened in simulation through a tick period
package pump_fault_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    // One supervision tick per second; all timers count ticks
    localparam int unsigned TICK_SEC = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;

    localparam logic [7:0] DRY_RUN_DELAY_DEFAULT_SEC = 8'h0a;
    localparam logic [7:0] SHORT_LOCKOUT_SEC = 8'h0a;

    localparam logic [16:0] RETRY_STAGE1_SEC = 17'h0_0258;
    localparam logic [16:0] RETRY_STAGE2_SEC = 17'h0_0e10;
    localparam logic [16:0] RETRY_STAGE3_SEC = 17'h1_5180;
    localparam logic [5:0] RETRY_STAGE1_COUNT = 6'h06;
    localparam logic [5:0] RETRY_STAGE2_COUNT = 6'h18;
    localparam logic [5:0] RETRY_STAGE3_COUNT = 6'h1e;

    localparam logic [7:0] STAGE_HOT_TRIP_C = 8'h64;
    localparam logic [7:0] STAGE_HOT_CLEAR_C = 8'h55;
    localparam logic [7:0] BOARD_HOT_TRIP_C = 8'h78;
    localparam logic [7:0] BOARD_HOT_CLEAR_C = 8'h64;
    localparam logic signed [7:0] FREEZE_NEAR_C = 8'sh03;

    // Halt codes; the numeric order is also display priority, lowest code wins
    typedef enum logic [3:0] {
        code_none,
        code_earth_short,
        code_ground_fault,
        code_phase_short,
        code_output_stage_overcurrent,
        code_motor_overcurrent,
        code_internal_overvoltage,
        code_undervoltage,
        code_power_stage_overheat,
        code_board_overheat,
        code_sensor_fault,
        code_water_failure
    } halt_code_t;

    localparam int unsigned NUM_RETRY = 3;
    localparam int unsigned RETRY_WATER = 0;
    localparam int unsigned RETRY_MOTOR_OC = 1;
    localparam int unsigned RETRY_STAGE_OC = 2;

    typedef struct packed {
        logic flow_low;
        logic pressure_below_setpoint;
        logic sensor_bad;
        logic line_undervoltage;
        logic internal_overvoltage;
        logic motor_overcurrent;
        logic output_stage_overcurrent;
        logic phase_short;
        logic earth_short;
        logic ground_fault;
        logic irregular_shutdown;
        logic cooling_trouble;
    } sense_t;

    typedef struct packed {
        logic water_failure_halt;
        logic sensor_fault_halt;
        logic undervoltage_halt;
        logic internal_overvoltage_halt;
        logic power_stage_overheat_halt;
        logic board_overheat_halt;
        logic motor_overcurrent_halt;
        logic output_stage_overcurrent_halt;
        logic phase_short_halt;
        logic earth_short_halt;
        logic ground_fault_halt;
    } halt_t;

endpackage

// ---- src/pump_protection_fault_manager.sv ----
// Purpose: Latch pump halt conditions, show the top one, stop the pump, clear faults
// Assumes: Sensor levels and keys arrive asynchronously; readings are settled values
// Notes: Timers advance once per tick; TICK_CYCLES may be shortened for simulation
`timescale 1ns/1ps

module pump_protection_fault_manager #(
    parameter int unsigned TICK_CYCLES = pump_fault_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire pump_fault_pkg::sense_t sense_in,
    input wire logic [7:0] power_stage_heat_reading,
    input wire logic [7:0] board_heat_reading,
    input wire logic signed [7:0] water_temp_reading,
    input wire logic [7:0] dry_run_delay,
    input wire logic key_plus,
    input wire logic key_minus,
    input wire logic demand_run,
    output pump_fault_pkg::halt_t halts,
    output pump_fault_pkg::halt_code_t display_code,
    output logic pump_run,
    output logic antifreeze_active,
    output logic abnormal_shutdown_entry,
    output logic cooling_trouble_entry
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned SW = $bits(pump_fault_pkg::sense_t) + 3;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    pump_fault_pkg::sense_t s;
    logic plus_s;
    logic minus_s;
    logic run_s;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {sense_in, key_plus, key_minus, demand_run};
            sync2 <= sync1;
        end
    end
    assign {s, plus_s, minus_s, run_s} = sync2;

    // ------------------------------------------------------------
    // Tick, keys, dry-run and lockout timers
    // ------------------------------------------------------------
    logic [31:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic both_held, next_both_held;
    logic key_release;
    logic [7:0] dry_cnt, next_dry_cnt;
    logic [7:0] short_age, next_short_age;
    logic dry_trip;
    logic [7:0] eff_delay;

    // A zero setting falls back to the factory delay rather than tripping instantly
    assign eff_delay = (dry_run_delay == 8'h00) ?
        pump_fault_pkg::DRY_RUN_DELAY_DEFAULT_SEC : dry_run_delay;
    assign key_release = both_held && !plus_s && !minus_s;
    assign dry_trip = (dry_cnt >= eff_delay);

    always_comb begin
        next_tick = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick_cnt = next_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        if (plus_s && minus_s) begin
            next_both_held = 1'b1;
        end else if (!plus_s && !minus_s) begin
            next_both_held = 1'b0;
        end else begin
            next_both_held = both_held;
        end
        next_dry_cnt = dry_cnt;
        if (!(s.flow_low && s.pressure_below_setpoint && pump_run)) begin
            next_dry_cnt = 8'h00;
        end else if (tick && dry_cnt != 8'hff) begin
            next_dry_cnt = dry_cnt + 8'h01;
        end
        next_short_age = short_age;
        if (s.phase_short) begin
            next_short_age = 8'h00;
        end else if (tick && short_age < pump_fault_pkg::SHORT_LOCKOUT_SEC) begin
            next_short_age = short_age + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
            both_held <= 1'b0;
            dry_cnt <= 8'h00;
            short_age <= 8'h00;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            both_held <= next_both_held;
            dry_cnt <= next_dry_cnt;
            short_age <= next_short_age;
        end
    end

    // ------------------------------------------------------------
    // Retry schedules for water failure and both overcurrents
    // ------------------------------------------------------------
    localparam int unsigned NR = pump_fault_pkg::NUM_RETRY;
    logic [NR-1:0] retry_fire;
    logic [NR-1:0] retry_halt;
    logic [NR-1:0] retry_cause;

    assign retry_halt = {halts.output_stage_overcurrent_halt,
                         halts.motor_overcurrent_halt, halts.water_failure_halt};
    // Water cause is unknowable while stopped, so the retry itself is the test
    assign retry_cause = {s.output_stage_overcurrent, s.motor_overcurrent, 1'b0};

    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_retry
            logic [1:0] stage, next_stage;
            logic [5:0] tries, next_tries;
            logic [16:0] secs, next_secs;
            logic [16:0] period;
            logic [5:0] limit;
            logic fire, next_fire;
            logic pending, next_pending;
            logic [8:0] quiet, next_quiet;

            always_comb begin
                case (stage)
                    2'd0: begin
                        period = pump_fault_pkg::RETRY_STAGE1_SEC;
                        limit = pump_fault_pkg::RETRY_STAGE1_COUNT;
                    end
                    2'd1: begin
                        period = pump_fault_pkg::RETRY_STAGE2_SEC;
                        limit = pump_fault_pkg::RETRY_STAGE2_COUNT;
                    end
                    default: begin
                        period = pump_fault_pkg::RETRY_STAGE3_SEC;
                        limit = pump_fault_pkg::RETRY_STAGE3_COUNT;
                    end
                endcase
                next_stage = stage;
                next_tries = tries;
                next_secs = secs;
                next_fire = 1'b0;
                // A halt that comes back during the trial ends it as a failed attempt
                next_pending = pending && !(retry_halt[g] && !fire);
                next_quiet = quiet;
                if (!retry_halt[g] && !pending) begin
                    next_stage = 2'd0;
                    next_tries = 6'h00;
                    next_secs = 17'h0_0000;
                    next_quiet = 9'h000;
                end else if (!retry_halt[g]) begin
                    // One quiet dry-run window after a retry counts as success
                    if (quiet > {1'b0, eff_delay}) begin
                        next_pending = 1'b0;
                    end else if (tick) begin
                        next_quiet = quiet + 9'h001;
                    end
                end else if (stage != 2'd3 && tick) begin
                    if (secs + 17'h0_0001 >= period) begin
                        next_secs = 17'h0_0000;
                        next_fire = !retry_cause[g];
                        next_pending = !retry_cause[g];
                        next_quiet = 9'h000;
                        if (tries + 6'h01 >= limit) begin
                            next_tries = 6'h00;
                            next_stage = stage + 2'd1;
                        end else begin
                            next_tries = tries + 6'h01;
                        end
                    end else begin
                        next_secs = secs + 17'h0_0001;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    stage <= 2'd0;
                    tries <= 6'h00;
                    secs <= 17'h0_0000;
                    fire <= 1'b0;
                    pending <= 1'b0;
                    quiet <= 9'h000;
                end else begin
                    stage <= next_stage;
                    tries <= next_tries;
                    secs <= next_secs;
                    fire <= next_fire;
                    pending <= next_pending;
                    quiet <= next_quiet;
                end
            end
            assign retry_fire[g] = fire;
        end
    endgenerate

    // ------------------------------------------------------------
    // Halt latches
    // ------------------------------------------------------------
    pump_fault_pkg::halt_t next_halts;
    logic short_clear_ok;
    assign short_clear_ok = short_age >= pump_fault_pkg::SHORT_LOCKOUT_SEC;

    always_comb begin
        next_halts = halts;
        // Water failure: manual or scheduled retry clears; a new trip wins
        if (key_release || retry_fire[pump_fault_pkg::RETRY_WATER]) begin
            next_halts.water_failure_halt = 1'b0;
        end
        if (dry_trip) begin
            next_halts.water_failure_halt = 1'b1;
        end
        next_halts.sensor_fault_halt = s.sensor_bad;
        next_halts.undervoltage_halt = s.line_undervoltage;
        next_halts.internal_overvoltage_halt = s.internal_overvoltage;
        if (power_stage_heat_reading > pump_fault_pkg::STAGE_HOT_TRIP_C) begin
            next_halts.power_stage_overheat_halt = 1'b1;
        end else if (power_stage_heat_reading < pump_fault_pkg::STAGE_HOT_CLEAR_C) begin
            next_halts.power_stage_overheat_halt = 1'b0;
        end
        if (board_heat_reading > pump_fault_pkg::BOARD_HOT_TRIP_C) begin
            next_halts.board_overheat_halt = 1'b1;
        end else if (board_heat_reading < pump_fault_pkg::BOARD_HOT_CLEAR_C) begin
            next_halts.board_overheat_halt = 1'b0;
        end
        if (key_release || retry_fire[pump_fault_pkg::RETRY_MOTOR_OC]) begin
            next_halts.motor_overcurrent_halt = 1'b0;
        end
        if (s.motor_overcurrent) begin
            next_halts.motor_overcurrent_halt = 1'b1;
        end
        if (key_release || retry_fire[pump_fault_pkg::RETRY_STAGE_OC]) begin
            next_halts.output_stage_overcurrent_halt = 1'b0;
        end
        if (s.output_stage_overcurrent) begin
            next_halts.output_stage_overcurrent_halt = 1'b1;
        end
        if (key_release && short_clear_ok) begin
            next_halts.phase_short_halt = 1'b0;
        end
        if (s.phase_short) begin
            next_halts.phase_short_halt = 1'b1;
        end
        // Earth faults have no clear path short of a system reset
        next_halts.earth_short_halt = halts.earth_short_halt | s.earth_short;
        next_halts.ground_fault_halt = halts.ground_fault_halt | s.ground_fault;
    end

    // ------------------------------------------------------------
    // Display priority, pump command and log entries
    // ------------------------------------------------------------
    pump_fault_pkg::halt_code_t next_display_code;
    logic next_pump_run, next_antifreeze;

    always_comb begin
        next_display_code = pump_fault_pkg::code_none;
        if (next_halts.earth_short_halt) begin
            next_display_code = pump_fault_pkg::code_earth_short;
        end else if (next_halts.ground_fault_halt) begin
            next_display_code = pump_fault_pkg::code_ground_fault;
        end else if (next_halts.phase_short_halt) begin
            next_display_code = pump_fault_pkg::code_phase_short;
        end else if (next_halts.output_stage_overcurrent_halt) begin
            next_display_code = pump_fault_pkg::code_output_stage_overcurrent;
        end else if (next_halts.motor_overcurrent_halt) begin
            next_display_code = pump_fault_pkg::code_motor_overcurrent;
        end else if (next_halts.internal_overvoltage_halt) begin
            next_display_code = pump_fault_pkg::code_internal_overvoltage;
        end else if (next_halts.undervoltage_halt) begin
            next_display_code = pump_fault_pkg::code_undervoltage;
        end else if (next_halts.power_stage_overheat_halt) begin
            next_display_code = pump_fault_pkg::code_power_stage_overheat;
        end else if (next_halts.board_overheat_halt) begin
            next_display_code = pump_fault_pkg::code_board_overheat;
        end else if (next_halts.sensor_fault_halt) begin
            next_display_code = pump_fault_pkg::code_sensor_fault;
        end else if (next_halts.water_failure_halt) begin
            next_display_code = pump_fault_pkg::code_water_failure;
        end
        next_antifreeze = (water_temp_reading <= pump_fault_pkg::FREEZE_NEAR_C);
        next_pump_run = (next_halts == '0) && (run_s || next_antifreeze);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            halts <= '0;
            display_code <= pump_fault_pkg::code_none;
            pump_run <= 1'b0;
            antifreeze_active <= 1'b0;
            abnormal_shutdown_entry <= 1'b0;
            cooling_trouble_entry <= 1'b0;
        end else begin
            halts <= next_halts;
            display_code <= next_display_code;
            pump_run <= next_pump_run;
            antifreeze_active <= next_antifreeze;
            abnormal_shutdown_entry <= s.irregular_shutdown;
            cooling_trouble_entry <= s.cooling_trouble;
        end
    end

endmodule

// ---- tb/pump_fault_sva.sv ----
// Purpose: Port assertions for the pump fault supervisor
// Assumes: Sense pins pass a two-stage synchroniser before use
// Notes: Antecedents on input pins span two or more cycles to absorb pipeline depth
`timescale 1ns/1ps
module pump_fault_sva #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire pump_fault_pkg::sense_t sense_in,
    input wire logic [7:0] power_stage_heat_reading,
    input wire logic [7:0] board_heat_reading,
    input wire logic signed [7:0] water_temp_reading,
    input wire pump_fault_pkg::halt_t halts,
    input wire pump_fault_pkg::halt_code_t display_code,
    input wire logic pump_run,
    input wire logic antifreeze_active,
    input wire logic abnormal_shutdown_entry
);
    // Tick phase is unknown, so ten ticks may span only nine full periods
    localparam int LOCK = 9 * TICK_CYCLES;
    int short_age;
    int next_short_age;
    always_comb begin
        next_short_age = short_age;
        if (!halts.phase_short_halt) begin
            next_short_age = 0;
        end else if (short_age < LOCK) begin
            next_short_age = short_age + 1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            short_age <= 0;
        end else begin
            short_age <= next_short_age;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_halt_stops_pump: assert property (|halts |-> !pump_run)
        else $error("pump runs while halted");
    a_top_earth: assert property (
        halts.earth_short_halt [*2] |-> display_code == pump_fault_pkg::code_earth_short)
        else $error("earth short not shown first");
    a_top_single: assert property (
        (halts == 11'h400) [*2] |-> display_code == pump_fault_pkg::code_water_failure)
        else $error("water code not shown");
    a_sensor_fast: assert property (
        sense_in.sensor_bad [*3] |-> ##[0:2] halts.sensor_fault_halt)
        else $error("sensor halt late");
    a_underv_holds: assert property (
        sense_in.line_undervoltage [*4] |-> halts.undervoltage_halt)
        else $error("undervoltage halt dropped");
    a_overv_holds: assert property (
        sense_in.internal_overvoltage [*4] |-> halts.internal_overvoltage_halt)
        else $error("overvoltage halt dropped");
    a_stage_trip: assert property (
        (power_stage_heat_reading > pump_fault_pkg::STAGE_HOT_TRIP_C) [*2]
        |-> halts.power_stage_overheat_halt)
        else $error("stage heat halt missing");
    a_stage_hyst: assert property (
        (halts.power_stage_overheat_halt
        && power_stage_heat_reading >= pump_fault_pkg::STAGE_HOT_CLEAR_C) [*2]
        |=> halts.power_stage_overheat_halt)
        else $error("stage heat halt cleared early");
    a_board_clear: assert property (
        (board_heat_reading < pump_fault_pkg::BOARD_HOT_CLEAR_C) [*3]
        |-> !halts.board_overheat_halt)
        else $error("board heat halt stuck");
    a_short_lock: assert property (
        halts.phase_short_halt && short_age < LOCK |=> halts.phase_short_halt)
        else $error("phase short cleared in lockout");
    a_freeze_run: assert property (
        (water_temp_reading <= pump_fault_pkg::FREEZE_NEAR_C) [*2] |-> antifreeze_active)
        else $error("antifreeze not active");
    a_log_follow: assert property (
        sense_in.irregular_shutdown [*4] |-> abnormal_shutdown_entry)
        else $error("shutdown entry missing");
    c_water_halt: cover property ($rose(halts.water_failure_halt));
    c_short_clear: cover property ($fell(halts.phase_short_halt));
    c_freeze: cover property ($rose(antifreeze_active));
endmodule
bind pump_protection_fault_manager pump_fault_sva #(.TICK_CYCLES(TICK_CYCLES)) u_pump_fault_sva (
    .core_clk(core_clk), .srst(srst), .sense_in(sense_in),
    .power_stage_heat_reading(power_stage_heat_reading), .board_heat_reading(board_heat_reading),
    .water_temp_reading(water_temp_reading), .halts(halts), .display_code(display_code),
    .pump_run(pump_run), .antifreeze_active(antifreeze_active),
    .abnormal_shutdown_entry(abnormal_shutdown_entry));

// ---- tb/pump_far_side.sv ----
// Purpose: Far-side model of the fault sensors and the plus/minus keypad
// Assumes: Levels change one step after a rising clock edge
// Notes: Keys are held long enough to pass the input synchroniser
`timescale 1ns/1ps
module pump_far_side (
    input wire logic core_clk,
    output pump_fault_pkg::sense_t sense_in,
    output logic key_plus,
    output logic key_minus
);
    initial begin
        sense_in = '0;
        key_plus = 1'b0;
        key_minus = 1'b0;
    end
    task automatic set_sense(input pump_fault_pkg::sense_t v);
        @(posedge core_clk);
        #1 sense_in = v;
    endtask
    // Both keys go down and come up together; the release asks for the clear
    task automatic press_keys();
        @(posedge core_clk);
        #1 key_plus = 1'b1;
        key_minus = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 key_plus = 1'b0;
        key_minus = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
endmodule

// ---- tb/pump_protection_fault_manager_test.sv ----
// Purpose: Self-checking bench for the pump fault supervisor
// Assumes: Tick shortened to 10 cycles; every timer scales with it
// Notes: Expected halts come from a bench model, never from the outputs
`timescale 1ns/1ps
module pump_protection_fault_manager_test;
    localparam int unsigned TICK = 10;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    pump_fault_pkg::sense_t sense_in;
    logic [7:0] stage_heat = 8'h19;
    logic [7:0] board_heat = 8'h19;
    logic signed [7:0] water_temp = 8'sh14;
    logic [7:0] delay_sec = 8'h02;
    logic key_plus;
    logic key_minus;
    logic demand = 1'b0;
    pump_fault_pkg::halt_t halts;
    pump_fault_pkg::halt_code_t display_code;
    logic pump_run;
    logic freeze;
    logic shut_log;
    logic cool_log;
    logic [10:0] exp_h = '0;
    logic exp_af = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    int n;
    int pri_bit [11] = '{1, 0, 2, 3, 4, 7, 8, 6, 5, 9, 10};
    logic [7:0] st [4] = '{8'h64, 8'h65, 8'h55, 8'h54};
    logic [7:0] bd [4] = '{8'h78, 8'h79, 8'h64, 8'h63};
    logic [1:0] ex [4] = '{2'h0, 2'h3, 2'h3, 2'h0};
    pump_fault_pkg::sense_t s = '0;
    always #5 core_clk = ~core_clk;
    pump_far_side u_pump_far_side (.core_clk(core_clk), .sense_in(sense_in),
        .key_plus(key_plus), .key_minus(key_minus));
    pump_protection_fault_manager #(.TICK_CYCLES(TICK)) u_pump_protection_fault_manager (
        .core_clk(core_clk), .srst(srst), .sense_in(sense_in),
        .power_stage_heat_reading(stage_heat), .board_heat_reading(board_heat),
        .water_temp_reading(water_temp), .dry_run_delay(delay_sec), .key_plus(key_plus),
        .key_minus(key_minus), .demand_run(demand), .halts(halts), .display_code(display_code),
        .pump_run(pump_run), .antifreeze_active(freeze), .abnormal_shutdown_entry(shut_log),
        .cooling_trouble_entry(cool_log));
    // ----------------------------------------
    // Helpers and bench model
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait for the water halt; running out counts as a mismatch
    task automatic wait_water(input int bound);
        n = 0;
        while (halts.water_failure_halt !== 1'b1 && n < bound) begin
            step(1);
            n++;
        end
        if (n >= bound) begin
            err_total++;
            summarize();
        end
    endtask
    // Priority walk: first set flag in display order gives the code
    function automatic logic [3:0] top(input logic [10:0] h);
        for (int i = 0; i < 11; i++) begin
            if (h[pri_bit[i]]) return 4'(i + 1);
        end
        return 4'h0;
    endfunction
    task automatic compare_all();
        chk("halts", halts, exp_h);
        chk("display", display_code, top(exp_h));
        chk("run", pump_run, exp_h == 0 && (demand || exp_af));
        chk("freeze", freeze, exp_af);
        chk("logs", {shut_log, cool_log}, {s.irregular_shutdown, s.cooling_trouble});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(52884));
        step(16);
        compare_all();
        srst = 1'b0;
        step(4);
        compare_all();
        demand = 1'b1;
        // Random mixes of self-clearing and overcurrent faults
        repeat (4) begin
            s = '0;
            s[9:5] = 5'($urandom_range(1, 31));
            s[1:0] = 2'($urandom());
            u_pump_far_side.set_sense(s);
            step(5);
            exp_h[9:7] = s[9:7];
            exp_h[4:3] = s[6:5];
            compare_all();
            u_pump_far_side.press_keys();
            compare_all();
            s = '0;
            u_pump_far_side.set_sense(s);
            step(5);
            exp_h[9:7] = 3'h0;
            compare_all();
            u_pump_far_side.press_keys();
            exp_h[4:3] = 2'h0;
            compare_all();
        end
        // Heat limits at and around both thresholds
        for (int i = 0; i < 4; i++) begin
            stage_heat = st[i];
            board_heat = bd[i];
            step(4);
            exp_h[6:5] = ex[i];
            compare_all();
        end
        // Short pulse, a clear refused inside the lockout, then one accepted after it
        s[4] = 1'b1;
        u_pump_far_side.set_sense(s);
        step(2);
        s = '0;
        u_pump_far_side.set_sense(s);
        step(4);
        exp_h[2] = 1'b1;
        u_pump_far_side.press_keys();
        compare_all();
        step(12 * TICK);
        u_pump_far_side.press_keys();
        exp_h[2] = 1'b0;
        compare_all();
        // Dry run with a two-second delay, then the first ten-minute retry
        s[11:10] = 2'h3;
        u_pump_far_side.set_sense(s);
        step(5);
        compare_all();
        wait_water(4 * TICK);
        s = '0;
        u_pump_far_side.set_sense(s);
        step(4);
        exp_h[10] = 1'b1;
        compare_all();
        step(585 * TICK);
        compare_all();
        step(25 * TICK);
        exp_h[10] = 1'b0;
        compare_all();
        // Near freezing the pump runs without demand
        demand = 1'b0;
        water_temp = 8'sh03;
        step(4);
        exp_af = 1'b1;
        compare_all();
        water_temp = 8'sh04;
        step(4);
        exp_af = 1'b0;
        compare_all();
        // Zero delay falls back to ten seconds; the keys then clear the water halt
        delay_sec = 8'h00;
        demand = 1'b1;
        s[11:10] = 2'h3;
        u_pump_far_side.set_sense(s);
        step(6 * TICK);
        compare_all();
        wait_water(8 * TICK);
        s = '0;
        u_pump_far_side.set_sense(s);
        step(4);
        exp_h[10] = 1'b1;
        compare_all();
        u_pump_far_side.press_keys();
        exp_h[10] = 1'b0;
        compare_all();
        // Earth faults outrank everything and survive the keys
        s[6] = 1'b1;
        s[3:2] = 2'h3;
        u_pump_far_side.set_sense(s);
        step(5);
        exp_h[4] = 1'b1;
        exp_h[1:0] = 2'h3;
        compare_all();
        s = '0;
        u_pump_far_side.set_sense(s);
        u_pump_far_side.press_keys();
        exp_h[4] = 1'b0;
        compare_all();
        summarize();
    end
endmodule
